// file: core/sif_top.sv
// stage status flags: high-limit and completion flags, pin change flag,
// interrupt enables and per-stage upper limits behind an AXI4-Lite slave
// assumes the converter pulses conv_done_i for one cycle on clk_sys_i
`timescale 1ns/1ps

// How it works
// - high-limit flags, twelve stages, reset zero
// - result above stage limit sets its flag
// - reading limit flags clears no-longer-exceeded ones
// - completion flags, twelve stages, reset zero
// - finished conversion sets its stage flag
// - pin level change sets bit twelve
// - enabled completion flag pulls interrupt low
// - enable bit twelve gates pin change interrupt
module sif_top
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [sif_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [sif_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [sif_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [sif_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic conv_done_i,
  input wire logic [sif_pkg::STAGE_W-1:0] conv_stage_i,
  input wire logic [sif_pkg::REG_W-1:0] conv_result_i,
  input wire logic gpio_pin_i,
  output logic irq_n_o
);
  import sif_pkg::*;

  logic cmp_vld_ff;
  logic [STAGE_W-1:0] cmp_stage_ff;
  logic [REG_W-1:0] cmp_result_ff;
  logic [REG_W-1:0] limit_rd_data;
  logic cmp_over;
  logic [NUM_STAGES-1:0] cmp_sel;
  logic [NUM_STAGES-1:0] over_now_ff;
  logic [NUM_STAGES-1:0] high_flags_ff;
  logic [NUM_STAGES-1:0] high_set;
  logic [NUM_STAGES-1:0] high_clr;
  logic [DONE_W-1:0] done_flags_ff;
  logic [DONE_W-1:0] done_set;
  logic [DONE_W-1:0] done_clr;
  logic [DONE_W-1:0] done_en_ff;
  logic [NUM_STAGES-1:0] high_en_ff;
  logic pin_chg;
  logic irq_n_ff;
  sif_rd_state_type rd_state_ff;
  logic [IDX_W-1:0] ar_idx;
  logic ar_take;
  logic ar_limit;
  logic [IDX_W-1:0] rd_idx_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [REG_W-1:0] reg_rd_val;
  logic reg_rd_hit;
  logic aw_held_ff;
  logic w_held_ff;
  logic [IDX_W-1:0] aw_idx_ff;
  logic [REG_W-1:0] wdata_ff;
  logic [1:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_fire;
  logic mem_rd_en;
  logic [STAGE_W-1:0] mem_rd_addr;

  // stage upper limits, read by the compare stage and by software
  sif_limit_mem u_limit_mem
  (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(wr_fire && sif_is_limit(aw_idx_ff)),
    .wr_addr_i(STAGE_W'(aw_idx_ff - IDX_LIMIT_BASE)),
    .wr_be_i(wstrb_ff),
    .wr_data_i(wdata_ff),
    .rd_en_i(mem_rd_en),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(limit_rd_data)
  );

  // pin change detector, pin is asynchronous
  sif_pin_sync u_pin_sync
  (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(gpio_pin_i),
    .chg_o(pin_chg)
  );

  // converter owns the read port on a done pulse; bus reads wait a cycle
  assign mem_rd_en = conv_done_i || (ar_take && ar_limit);
  assign mem_rd_addr = conv_done_i ? conv_stage_i : STAGE_W'(ar_idx - IDX_LIMIT_BASE);

  // hold the result while the stage limit is fetched
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      cmp_vld_ff <= 1'b0;
      cmp_stage_ff <= '0;
      cmp_result_ff <= '0;
    end
    else
    begin
      cmp_vld_ff <= conv_done_i;
      if (conv_done_i)
      begin
        cmp_stage_ff <= conv_stage_i;
        cmp_result_ff <= conv_result_i;
      end
    end
  end

  // strictly above the limit counts as exceeded
  assign cmp_sel = cmp_vld_ff ? sif_stage_onehot(cmp_stage_ff) : '0;
  assign cmp_over = (|cmp_sel) && (cmp_result_ff > limit_rd_data);

  // live exceeded state per stage, refreshed by each conversion of it
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      over_now_ff <= '0;
    else if (|cmp_sel)
      over_now_ff <= (over_now_ff & ~cmp_sel) | (cmp_over ? cmp_sel : '0);
  end

  // high-limit flags: set wins over the clear of the same cycle
  assign high_set = cmp_over ? cmp_sel : '0;
  assign high_clr = (ar_take && ar_idx == IDX_HIGH_FLAGS) ? ~over_now_ff : '0;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      high_flags_ff <= RST_HIGH_FLAGS;
    else
      high_flags_ff <= (high_flags_ff & ~high_clr) | high_set;
  end

  // completion and pin change flags, cleared by a read of their register
  assign done_set = {pin_chg, cmp_sel};
  assign done_clr = (ar_take && ar_idx == IDX_DONE_FLAGS) ? '1 : '0;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      done_flags_ff <= RST_DONE_FLAGS;
    else
      done_flags_ff <= (done_flags_ff & ~done_clr) | done_set;
  end

  // interrupt enables, written only through a completed write
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      done_en_ff <= RST_DONE_IRQ_EN;
      high_en_ff <= RST_HIGH_IRQ_EN;
    end
    else if (wr_fire)
    begin
      if (aw_idx_ff == IDX_DONE_IRQ_EN)
        done_en_ff <= DONE_W'(sif_apply_strb(REG_W'(done_en_ff), wdata_ff, wstrb_ff));
      if (aw_idx_ff == IDX_HIGH_IRQ_EN)
        high_en_ff <= NUM_STAGES'(sif_apply_strb(REG_W'(high_en_ff), wdata_ff, wstrb_ff));
    end
  end

  // active-low level interrupt, registered so it never glitches
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      irq_n_ff <= 1'b1;
    else
      irq_n_ff <= !((|(done_flags_ff & done_en_ff)) || (|(high_flags_ff & high_en_ff)));
  end

  assign irq_n_o = irq_n_ff;

  // read decode, narrow registers sit in the low bits
  always_comb
  begin
    reg_rd_val = '0;
    reg_rd_hit = 1'b1;
    case (ar_idx)
      IDX_HIGH_FLAGS: reg_rd_val = REG_W'(high_flags_ff);
      IDX_DONE_FLAGS: reg_rd_val = REG_W'(done_flags_ff);
      IDX_DONE_IRQ_EN: reg_rd_val = REG_W'(done_en_ff);
      IDX_HIGH_IRQ_EN: reg_rd_val = REG_W'(high_en_ff);
      IDX_OVER_LIVE: reg_rd_val = REG_W'(over_now_ff);
      default: reg_rd_hit = ar_limit;
    endcase
  end

  assign ar_idx = sif_word_idx(s_axi_araddr_i);
  assign ar_limit = sif_is_limit(ar_idx);
  assign s_axi_arready_o = (rd_state_ff == SIF_RD_IDLE) && !conv_done_i;
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

  // read channel: one read in flight, limit reads take one extra cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rd_state_ff <= SIF_RD_IDLE;
      rd_idx_ff <= '0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      case (rd_state_ff)
        SIF_RD_IDLE:
        begin
          if (ar_take)
          begin
            rd_idx_ff <= ar_idx;
            rresp_ff <= reg_rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= DATA_W'(reg_rd_val);
            rd_state_ff <= ar_limit ? SIF_RD_MEM : SIF_RD_RESP;
          end
        end
        SIF_RD_MEM:
        begin
          rdata_ff <= DATA_W'(limit_rd_data);
          rd_state_ff <= SIF_RD_RESP;
        end
        SIF_RD_RESP:
        begin
          if (s_axi_rready_i)
            rd_state_ff <= SIF_RD_IDLE;
        end
        default: rd_state_ff <= SIF_RD_IDLE;
      endcase
    end
  end

  assign s_axi_rvalid_o = (rd_state_ff == SIF_RD_RESP);
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // write channel: address and data caught in either order
  assign s_axi_awready_o = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= sif_word_idx(s_axi_awaddr_i);
      end
      else if (wr_fire)
        aw_held_ff <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i[REG_W-1:0];
        wstrb_ff <= s_axi_wstrb_i[1:0];
      end
      else if (wr_fire)
        w_held_ff <= 1'b0;
    end
  end

  // write answer; status registers accept and ignore writes
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      case (aw_idx_ff)
        IDX_HIGH_FLAGS, IDX_DONE_FLAGS, IDX_OVER_LIVE: bresp_ff <= RESP_OKAY;
        IDX_DONE_IRQ_EN, IDX_HIGH_IRQ_EN: bresp_ff <= RESP_OKAY;
        default: bresp_ff <= sif_is_limit(aw_idx_ff) ? RESP_OKAY : RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready_i)
      bvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;

  // checks on flag behaviour
  property p_high_reset;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> high_flags_ff == RST_HIGH_FLAGS;
  endproperty
  a_high_reset: assert property (p_high_reset) else $error("high flags not zero after reset");

  property p_high_set;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    cmp_over |=> high_flags_ff[$past(cmp_stage_ff)];
  endproperty
  a_high_set: assert property (p_high_set) else $error("exceeded limit did not set flag");

  property p_high_rd_clr;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ar_take && ar_idx == IDX_HIGH_FLAGS && !cmp_vld_ff
      |=> high_flags_ff == $past(high_flags_ff & over_now_ff);
  endproperty
  a_high_rd_clr: assert property (p_high_rd_clr) else $error("high flags wrong after read");

  property p_done_reset;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> done_flags_ff == RST_DONE_FLAGS;
  endproperty
  a_done_reset: assert property (p_done_reset) else $error("done flags not zero after reset");

  property p_done_set;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    conv_done_i && conv_stage_i < STAGE_W'(NUM_STAGES) |-> ##2 done_flags_ff[$past(conv_stage_i, 2)];
  endproperty
  a_done_set: assert property (p_done_set) else $error("completion flag not set");

  property p_pin_set;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    pin_chg |=> done_flags_ff[PIN_CHG_BIT];
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pin change flag not set");

  property p_done_irq;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (done_flags_ff[NUM_STAGES-1:0] & done_en_ff[NUM_STAGES-1:0]) != '0 |=> !irq_n_o;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("enabled completion gave no irq");

  property p_pin_irq_off;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !done_en_ff[PIN_CHG_BIT] && (done_flags_ff[NUM_STAGES-1:0] & done_en_ff[NUM_STAGES-1:0]) == '0
      && (high_flags_ff & high_en_ff) == '0 |=> irq_n_o;
  endproperty
  a_pin_irq_off: assert property (p_pin_irq_off) else $error("disabled source drove irq");

  property p_upper_zero;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_axi_rvalid_o && (rd_idx_ff == IDX_HIGH_FLAGS || rd_idx_ff == IDX_DONE_FLAGS)
      |-> rdata_ff[DATA_W-1:DONE_W] == '0 && s_axi_rresp_o == RESP_OKAY;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("status upper bits not zero");

endmodule : sif_top

// file: core/sif_pkg.sv
// stage status flag block: shared constants, types and helper functions
// assumes a 50 MHz system clock and word-indexed registers on a 32-bit bus
package sif_pkg;

  // geometry
  localparam int unsigned NUM_STAGES = 12;
  localparam int unsigned STAGE_W = 4;
  localparam int unsigned REG_W = 16;
  localparam int unsigned DONE_W = 13;
  localparam int unsigned PIN_CHG_BIT = 12;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned DATA_W = 32;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_HIGH_FLAGS = 10'h009;
  localparam logic [IDX_W-1:0] IDX_DONE_FLAGS = 10'h00a;
  localparam logic [IDX_W-1:0] IDX_DONE_IRQ_EN = 10'h040;
  localparam logic [IDX_W-1:0] IDX_HIGH_IRQ_EN = 10'h041;
  localparam logic [IDX_W-1:0] IDX_OVER_LIVE = 10'h044;
  localparam logic [IDX_W-1:0] IDX_LIMIT_BASE = 10'h050;

  // values after reset
  localparam logic [NUM_STAGES-1:0] RST_HIGH_FLAGS = 12'h000;
  localparam logic [DONE_W-1:0] RST_DONE_FLAGS = 13'h0000;
  localparam logic [DONE_W-1:0] RST_DONE_IRQ_EN = 13'h0000;
  localparam logic [NUM_STAGES-1:0] RST_HIGH_IRQ_EN = 12'h000;
  localparam logic [REG_W-1:0] RST_LIMIT_RD = 16'h0000;

  // pin synchroniser settle time in cycles
  localparam logic [1:0] SYNC_WARM_CYCLES = 2'h3;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SIF_RD_IDLE, SIF_RD_MEM, SIF_RD_RESP} sif_rd_state_type;

  // byte address to register index
  function automatic logic [IDX_W-1:0] sif_word_idx(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction : sif_word_idx

  // true when an index falls in the per-stage limit window
  function automatic logic sif_is_limit(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] off;
    off = idx - IDX_LIMIT_BASE;
    return off < IDX_W'(NUM_STAGES);
  endfunction : sif_is_limit

  // one-hot stage select, all zero for stage numbers past the last stage
  function automatic logic [NUM_STAGES-1:0] sif_stage_onehot(input logic [STAGE_W-1:0] stage);
    logic [NUM_STAGES-1:0] oh;
    oh = '0;
    if (stage < STAGE_W'(NUM_STAGES))
      oh[stage] = 1'b1;
    return oh;
  endfunction : sif_stage_onehot

  // merge write data into a 16-bit register under the low two byte strobes
  function automatic logic [REG_W-1:0] sif_apply_strb(input logic [REG_W-1:0] old,
                                                      input logic [REG_W-1:0] data,
                                                      input logic [1:0] strb);
    logic [REG_W-1:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction : sif_apply_strb

endpackage : sif_pkg

// file: core/sif_limit_mem.sv
// per-stage upper limit store: one write port with byte enables, one read port
// assumes caller keeps addresses below the stage count; others read zero
`timescale 1ns/1ps

module sif_limit_mem
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [sif_pkg::STAGE_W-1:0] wr_addr_i,
  input wire logic [1:0] wr_be_i,
  input wire logic [sif_pkg::REG_W-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [sif_pkg::STAGE_W-1:0] rd_addr_i,
  output logic [sif_pkg::REG_W-1:0] rd_data_o
);
  import sif_pkg::*;

  logic [REG_W-1:0] mem_ff [NUM_STAGES];

  // storage holds no reset, software must program limits before use
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i && (wr_addr_i < STAGE_W'(NUM_STAGES)))
      mem_ff[wr_addr_i] <= sif_apply_strb(mem_ff[wr_addr_i], wr_data_i, wr_be_i);
  end

  // registered read, value appears one cycle after the request
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      rd_data_o <= RST_LIMIT_RD;
    else if (rd_en_i)
      rd_data_o <= (rd_addr_i < STAGE_W'(NUM_STAGES)) ? mem_ff[rd_addr_i] : '0;
  end

endmodule : sif_limit_mem

// file: core/sif_pin_sync.sv
// two-flop synchroniser for the general-purpose pin with change detection
// assumes the pin is asynchronous to clk_sys_i
`timescale 1ns/1ps

module sif_pin_sync
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic chg_o
);
  import sif_pkg::*;

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic [1:0] warm_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // hide the edge seen while the chain fills, a high pin at reset is no change
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      warm_ff <= '0;
    else if (warm_ff != SYNC_WARM_CYCLES)
      warm_ff <= warm_ff + 2'h1;
  end

  assign chg_o = (warm_ff == SYNC_WARM_CYCLES) && (sync_ff ^ last_ff);

endmodule : sif_pin_sync

// file: test/sif_host_model.sv
// host model: AXI4-Lite master reaching the status flag registers
// assumes callers enter its tasks just after a rising edge of clk_sys_i
`timescale 1ns/1ps

module sif_host_model
(
  input wire logic clk_sys_i,
  output logic [sif_pkg::ADDR_W-1:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [sif_pkg::ADDR_W-1:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  import sif_pkg::*;

  // idle bus; payload lines are scrambled once released
  initial
  begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
  end

  // ready is looked at on the falling edge, where it is already settled for the rising one
  task automatic bus_write(input logic [ADDR_W-1:0] addr, input logic [31:0] data,
                           output logic [1:0] resp);
    logic aw_hit, w_hit, b_hit;
    b_hit = 1'b0;
    awaddr_o <= addr;
    wdata_o <= data;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!b_hit)
    begin
      @(negedge clk_sys_i);
      aw_hit = awvalid_o && awready_i;
      w_hit = wvalid_o && wready_i;
      b_hit = bvalid_i;
      resp = bresp_i;
      @(posedge clk_sys_i);
      if (aw_hit) awvalid_o <= 1'b0;
      if (aw_hit) awaddr_o <= ~addr;
      if (w_hit) wvalid_o <= 1'b0;
      if (w_hit) wdata_o <= ~data;
    end
  endtask : bus_write

  // one read at a time; rready and bready stay high after their answer, so
  // back-to-back calls never lower and raise them in one time step
  task automatic bus_read(input logic [ADDR_W-1:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic ar_hit, r_hit;
    r_hit = 1'b0;
    araddr_o <= addr;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while (!r_hit)
    begin
      @(negedge clk_sys_i);
      ar_hit = arvalid_o && arready_i;
      r_hit = rvalid_i;
      data = rdata_i;
      resp = rresp_i;
      @(posedge clk_sys_i);
      if (ar_hit) arvalid_o <= 1'b0;
      if (ar_hit) araddr_o <= ~addr;
    end
  endtask : bus_read

endmodule : sif_host_model

// file: test/test_sif_top.sv
// self-checking bench for the stage status flag block
// assumes the host model as bus master; converter and pin driven here
`timescale 1ns/1ps

module test_sif_top;
  import sif_pkg::*;
  localparam logic [ADDR_W-1:0] A_HIGH = {IDX_HIGH_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] A_DONE = {IDX_DONE_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] A_EN = {IDX_DONE_IRQ_EN, 2'b00};
  localparam logic [ADDR_W-1:0] A_BAD = 12'hffc;
  logic clk_sys_i, sys_rst_i, conv_done, gpio_pin, irq_n;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, conv_stage, st;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] conv_result, res;
  logic [15:0] lim [NUM_STAGES];
  logic [NUM_STAGES-1:0] exp_high, over_live;
  logic [DONE_W-1:0] exp_done;
  int miscompares, num_checks, cyc, n;

  sif_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .conv_done_i(conv_done),
    .conv_stage_i(conv_stage), .conv_result_i(conv_result), .gpio_pin_i(gpio_pin),
    .irq_n_o(irq_n));

  sif_host_model host (.clk_sys_i(clk_sys_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  // 50 MHz system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // hang guard, far above the expected several hundred cycles
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 30000) miscompares++;
    if (cyc == 30000) final_report();
  end

  function automatic logic [ADDR_W-1:0] lim_addr(input int s);
    return {IDX_LIMIT_BASE + IDX_W'(s), 2'b00};
  endfunction : lim_addr

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) miscompares++;
    if (got !== exp) $display("mismatch at %0t: got %h expected %h", $time, got, exp);
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) miscompares++;
    if (got !== exp) $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
  endtask : chk_resp

  // irq_n is a flop output: look at mid-cycle, never in the launching time step
  task automatic chk_irq(input logic exp);
    @(negedge clk_sys_i);
    num_checks++;
    if (irq_n !== exp) miscompares++;
    if (irq_n !== exp) $display("mismatch at %0t: irq_n %h expected %h", $time, irq_n, exp);
    @(posedge clk_sys_i);
  endtask : chk_irq

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] r);
    host.bus_read(a, rd, rsp);
    chk_resp(rsp, r);
    chk_data(rd, e);
  endtask : rd_chk

  // read-clear of both flag registers, mirrored in the model
  task automatic rd_flags();
    rd_chk(A_HIGH, {20'h0_0000, exp_high}, RESP_OKAY);
    exp_high = exp_high & over_live;
    rd_chk(A_DONE, {19'h0_0000, exp_done}, RESP_OKAY);
    exp_done = '0;
  endtask : rd_flags

  // one conversion pulse; result and stage are junk outside it
  // more keeps the strobe up for a back-to-back pulse instead of dropping and raising it
  task automatic conv(input logic [3:0] s, input logic [15:0] r, input bit more = 1'b0);
    conv_done <= 1'b1;
    conv_stage <= s;
    conv_result <= r;
    @(posedge clk_sys_i);
    if (!more) conv_done <= 1'b0;
    if (!more) conv_stage <= 4'($urandom);
    if (!more) conv_result <= 16'($urandom);
    if (s < NUM_STAGES) exp_done[s] = 1'b1;
    if (s < NUM_STAGES) over_live[s] = r > lim[s];
    if (s < NUM_STAGES && r > lim[s]) exp_high[s] = 1'b1;
  endtask : conv

  task automatic pin_flip();
    gpio_pin <= ~gpio_pin;
    exp_done[PIN_CHG_BIT] = 1'b1;
    repeat (8) @(posedge clk_sys_i);
  endtask : pin_flip

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // main sequence
  initial
  begin
    void'($urandom(32'h6dbe));
    {sys_rst_i, conv_done, conv_stage, conv_result, gpio_pin} = {1'b1, 21'h00_0000, 1'b0};
    {exp_high, over_live, exp_done} = '0;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk_irq(1'b1);
    rd_flags();
    $display("test reset done");
    // corner limits: stage 0 can never be over, stage 1 is over on anything above zero
    for (int s = 0; s < NUM_STAGES; s++)
    begin
      lim[s] = (s == 0) ? 16'hffff : (s == 1) ? 16'h0000 : 16'($urandom);
      host.bus_write(lim_addr(s), {16'h0000, lim[s]}, rsp);
      chk_resp(rsp, RESP_OKAY);
      rd_chk(lim_addr(s), {16'h0000, lim[s]}, RESP_OKAY);
    end
    $display("test limits done");
    // back-to-back conversions, results at or just over the limit, or anywhere in range
    repeat (40)
    begin
      n = 1 + $urandom % 3;
      for (int k = 0; k < n; k++)
      begin
        st = 4'($urandom);
        res = lim[st % NUM_STAGES] + 16'($urandom % 2);
        if ($urandom % 3 == 0) res = 16'($urandom);
        conv(st, res, k < n - 1);
      end
      repeat (4) @(posedge clk_sys_i);
      rd_flags();
      rd_chk(A_HIGH, {20'h0_0000, exp_high}, RESP_OKAY);
      exp_high = exp_high & over_live;
      chk_irq(1'b1);
    end
    $display("test conversions done");
    pin_flip();
    rd_flags();
    rd_flags();
    $display("test pin done");
    st = 4'($urandom % NUM_STAGES);
    host.bus_write(A_EN, 32'h0000_0001 << st, rsp);
    conv((st + 4'h1) % 4'hc, 16'($urandom));
    repeat (4) @(posedge clk_sys_i);
    chk_irq(1'b1);
    conv(st, 16'($urandom));
    repeat (3) @(posedge clk_sys_i);
    chk_irq(1'b0);
    rd_flags();
    repeat (2) @(posedge clk_sys_i);
    chk_irq(1'b1);
    host.bus_write(A_EN, 32'h0000_1000, rsp);
    conv(st, 16'($urandom));
    repeat (4) @(posedge clk_sys_i);
    chk_irq(1'b1);
    pin_flip();
    chk_irq(1'b0);
    rd_flags();
    repeat (2) @(posedge clk_sys_i);
    chk_irq(1'b1);
    host.bus_write(A_EN, 32'h0000_0000, rsp);
    pin_flip();
    chk_irq(1'b1);
    $display("test interrupt done");
    conv(4'h1, 16'h0005);
    repeat (4) @(posedge clk_sys_i);
    host.bus_write(A_HIGH, 32'hffff_ffff, rsp);
    chk_resp(rsp, RESP_OKAY);
    host.bus_write(A_DONE, 32'hffff_ffff, rsp);
    chk_resp(rsp, RESP_OKAY);
    rd_flags();
    // stage 1 stays over its zero limit, so its sticky flag alone must drive the irq
    host.bus_write({IDX_HIGH_IRQ_EN, 2'b00}, 32'h0000_0002, rsp);
    chk_resp(rsp, RESP_OKAY);
    chk_irq(1'b0);
    rd_chk({IDX_HIGH_IRQ_EN, 2'b00}, 32'h0000_0002, RESP_OKAY);
    rd_chk({IDX_OVER_LIVE, 2'b00}, {20'h0_0000, over_live}, RESP_OKAY);
    host.bus_write(A_BAD, 32'hffff_ffff, rsp);
    chk_resp(rsp, RESP_SLVERR);
    rd_chk(A_BAD, 32'h0000_0000, RESP_SLVERR);
    $display("test read-only done");
    final_report();
  end

endmodule : test_sif_top
